// [rtl/tx_descriptor_command_decode.sv]
`timescale 1ns/100ps
// Function
// - command byte bit map, seven down to zero
// - rs with ide loads delay countdown
// - countdown zero raises masked transmit interrupt
// - every ide descriptor reloads running countdown
// - rs without ide interrupts now, clears timer
// - vlan tag insertion forces crc append
// - tag request ignored without vlan mode
// - report after send waits for wire
// - pending send blocks head and write-backs
// - rs requests status write-back
// - checksum from begin offset, written at offset
// - checksum ignored for out-of-range offsets
// - untagged frames append crc on request
// - last fragment ends the packet
// - packet options honoured only at last fragment
// - done flag only with report completion
// - empty descriptors move no data
// - write-back immediate unless bursting enabled
// - done flag at status bit zero
// - done covers all earlier descriptors
module tx_descriptor_command_decode (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // descriptor fetched in ring order
  input wire logic desc_valid_i,
  input wire tx_cmd_pkg::desc_t desc_i,
  output logic desc_ready_o,
  // packet controls toward the datapath
  output logic data_valid_o,
  output tx_cmd_pkg::pkt_ctl_t data_ctl_o,
  input wire logic data_ready_i,
  // end of wire transmission for a report_after_send packet
  input wire logic sent_i,
  // write-back request toward memory
  output logic wb_req_o,
  output tx_cmd_pkg::wb_t wb_info_o,
  input wire logic wb_done_i,
  // burst flush from the write-back coalescer
  input wire logic burst_flush_i,
  output logic head_adv_o,
  output logic [15:0] head_o,
  output logic tx_irq_o
);
  import tx_cmd_pkg::*;

  typedef enum logic [1:0] {IDLE, ISSUE, WAIT_SENT, WRITE} state_t;
  state_t state_r, state_nxt;

  logic [3:0] ctrl_r;
  logic [15:0] delay_r;
  logic [15:0] vtype_r;
  logic [15:0] timer_r;
  logic [15:0] head_r;
  logic [15:0] idx_r;
  logic [7:0] cmd_r;
  logic irq_r;
  logic ack_r;
  pkt_ctl_t ctl_r;

  // field decode of the latched command byte
  wire eop = cmd_r[CMD_EOP];
  wire want_crc_append_request = cmd_r[CMD_CRC_APPEND_REQUEST];
  wire want_ic = cmd_r[CMD_IC];
  wire want_rs = cmd_r[CMD_RS];
  wire want_rps = cmd_r[CMD_RPS] & eop & ctrl_r[CTL_RPS_SUP];
  wire want_vle = cmd_r[CMD_VLE];
  wire want_ide = cmd_r[CMD_IDE];
  // extension bit is not decoded: legacy layout assumed

  wire in_cmd = desc_i.cmd[CMD_EOP];
  wire vlan_on = in_cmd & desc_i.cmd[CMD_VLE] & ctrl_r[CTL_VME];
  wire css_ok = {8'h00, desc_i.checksum_begin_offset} < desc_i.len;
  wire cso_ok = {8'h00, desc_i.cso} < (desc_i.len - LEN_ONE);
  wire csum_on = in_cmd & desc_i.cmd[CMD_IC] & css_ok & cso_ok &
    (desc_i.len != TIMER_ZERO);
  wire fcs_on = in_cmd & (vlan_on | desc_i.cmd[CMD_CRC_APPEND_REQUEST]);
  wire empty = (desc_i.addr == 64'h0) | (desc_i.len == TIMER_ZERO);

  wire take = (state_r == IDLE) & desc_valid_i;
  wire issued = (state_r == ISSUE) & (data_ready_i | ctl_r.no_data);
  wire wb_fire = (state_r == WRITE) & wb_done_i;
  wire retire_plain = issued & ~want_rps & ~want_rs;
  wire retire = wb_fire | retire_plain;
  // write-back may be held for bursting, never for the interrupt delay
  wire go_write = ~ctrl_r[CTL_BURST] | burst_flush_i;

  // bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wr = bus_req & wb_we_i;
  wire hit_ctrl = wb_adr_i == ADDR_CTRL;
  wire hit_delay = wb_adr_i == ADDR_DELAY;
  wire hit_vtype = wb_adr_i == ADDR_VTYPE;
  wire hit_stat = wb_adr_i == ADDR_STAT;
  wire hit_head = wb_adr_i == ADDR_HEAD;
  wire [31:0] rd_data =
    hit_ctrl ? {28'h0, ctrl_r} :
    hit_delay ? {16'h0, delay_r} :
    hit_vtype ? {16'h0, vtype_r} :
    hit_stat ? {13'h0, irq_r, state_r, timer_r} :
    hit_head ? {16'h0, head_r} : 32'h0;

  // interrupt timing
  wire rs_done = wb_fire & want_rs;
  wire load_timer = issued & want_ide;
  wire load_rs = rs_done & want_ide;
  wire imm_irq = rs_done & ~want_ide;
  wire expire = (timer_r == TIMER_ONE) & ~load_timer & ~load_rs;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      IDLE: if (take) state_nxt = ISSUE;
      ISSUE: begin
        if (issued & want_rps) state_nxt = WAIT_SENT;
        else if (issued & want_rs) state_nxt = WRITE;
        else if (issued) state_nxt = IDLE;
      end
      // nothing is written back or advanced until the wire reports
      WAIT_SENT: if (sent_i) state_nxt = WRITE;
      WRITE: if (wb_fire) state_nxt = IDLE;
    endcase
  end

  assign desc_ready_o = state_r == IDLE;
  assign data_valid_o = (state_r == ISSUE) & ~ctl_r.no_data;
  assign data_ctl_o = ctl_r;
  assign wb_req_o = (state_r == WRITE) & go_write;
  assign wb_info_o = '{index: idx_r, status: 8'h01 << STA_DONE};
  assign head_adv_o = retire;
  assign head_o = head_r;
  assign tx_irq_o = irq_r;
  assign wb_dat_o = ack_r ? rd_data : 32'h0;
  assign wb_ack_o = ack_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= IDLE;
      cmd_r <= 8'h00;
      ctl_r <= '0;
      idx_r <= 16'h0000;
      head_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      if (take) begin
        cmd_r <= desc_i.cmd;
        idx_r <= head_r;
        ctl_r <= '{eop: in_cmd, vlan: vlan_on, fcs: fcs_on, csum: csum_on,
                   checksum_begin_offset: desc_i.checksum_begin_offset, cso: desc_i.cso, vtype: vtype_r,
                   tag: desc_i.special, no_data: empty};
      end
      if (retire) head_r <= head_r + HEAD_ONE;
    end
  end

  // countdown: reload wins over expiry; rs without ide clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_r <= TIMER_ZERO;
      irq_r <= 1'b0;
    end else begin
      if (load_rs | load_timer) timer_r <= delay_r;
      else if (imm_irq) timer_r <= TIMER_ZERO;
      else if (timer_r != TIMER_ZERO) timer_r <= timer_r - TIMER_ONE;
      // a zero delay would never count, so an rs reload with it fires at once
      if ((expire | imm_irq | (load_rs & (delay_r == TIMER_ZERO))) &
          ctrl_r[CTL_MASK]) begin
        irq_r <= 1'b1;
      end else if (wr & hit_stat) begin
        irq_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
      delay_r <= DELAY_RST;
      vtype_r <= VTYPE_RST;
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req;
      if (wr & hit_ctrl & wb_sel_i[0]) ctrl_r <= wb_dat_i[3:0];
      if (wr & hit_delay & wb_sel_i[0]) delay_r[7:0] <= wb_dat_i[7:0];
      if (wr & hit_delay & wb_sel_i[1]) delay_r[15:8] <= wb_dat_i[15:8];
      if (wr & hit_vtype & wb_sel_i[0]) vtype_r[7:0] <= wb_dat_i[7:0];
      if (wr & hit_vtype & wb_sel_i[1]) vtype_r[15:8] <= wb_dat_i[15:8];
    end
  end
endmodule

// [rtl/tx_cmd_pkg.sv]
package tx_cmd_pkg;
  // command byte fields
  localparam int CMD_EOP = 0;
  localparam int CMD_CRC_APPEND_REQUEST = 1;
  localparam int CMD_IC = 2;
  localparam int CMD_RS = 3;
  localparam int CMD_RPS = 4;
  localparam int CMD_FORMAT_EXTENSION = 5;
  localparam int CMD_VLE = 6;
  localparam int CMD_IDE = 7;
  localparam int STA_DONE = 0;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DELAY = 8'h04;
  localparam logic [7:0] ADDR_VTYPE = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_HEAD = 8'h10;
  // control register bits
  localparam int CTL_VME = 0;
  localparam int CTL_MASK = 1;
  localparam int CTL_BURST = 2;
  localparam int CTL_RPS_SUP = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [15:0] VTYPE_RST = 16'h8100;
  localparam logic [15:0] TIMER_ZERO = 16'h0000;
  localparam logic [15:0] TIMER_ONE = 16'h0001;
  localparam logic [15:0] HEAD_ONE = 16'h0001;
  localparam logic [15:0] LEN_ONE = 16'h0001;

  typedef struct packed {
    logic [63:0] addr;
    logic [15:0] len;
    logic [7:0] cso;
    logic [7:0] cmd;
    logic [7:0] checksum_begin_offset;
    logic [15:0] special;
  } desc_t;

  typedef struct packed {
    logic eop;
    logic vlan;
    logic fcs;
    logic csum;
    logic [7:0] checksum_begin_offset;
    logic [7:0] cso;
    logic [15:0] vtype;
    logic [15:0] tag;
    logic no_data;
  } pkt_ctl_t;

  typedef struct packed {
    logic [15:0] index;
    logic [7:0] status;
  } wb_t;
endpackage

// [tb/host_mem_model.sv]
`timescale 1ns/100ps
module host_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic data_valid_i,
  input wire logic wb_req_i,
  output logic data_ready_o,
  output logic wb_done_o
);
  logic [1:0] wait_r;
  logic go;
  // slow mode stalls so the block has to hold its offers
  assign go = !slow_i || wait_r == 2'h3;
  always_ff @(posedge clk_i) begin
    if (rst_i || data_ready_o || wb_done_o) begin
      wait_r <= 2'h0;
    end else if (data_valid_i || wb_req_i) begin
      wait_r <= wait_r + 2'h1;
    end
  end
  assign data_ready_o = data_valid_i && go;
  assign wb_done_o = wb_req_i && !data_valid_i && go;
endmodule

// [tb/tx_descriptor_command_decode_props.sv]
`timescale 1ns/100ps
module tx_cmd_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic desc_ready_o,
  input wire logic data_valid_o,
  input wire tx_cmd_pkg::pkt_ctl_t data_ctl_o,
  input wire logic wb_req_o,
  input wire tx_cmd_pkg::wb_t wb_info_o,
  input wire logic wb_done_i,
  input wire logic head_adv_o,
  input wire logic [15:0] head_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_vlan_crc: assert property (data_valid_o && data_ctl_o.vlan |-> data_ctl_o.fcs)
    else $error("tagged frame without crc");
  chk_opt_last: assert property (data_valid_o && (data_ctl_o.vlan ||
    data_ctl_o.fcs || data_ctl_o.csum) |-> data_ctl_o.eop)
    else $error("option on inner fragment");
  chk_one_flight: assert property (data_valid_o || wb_req_o |-> !desc_ready_o)
    else $error("second descriptor taken");
  chk_done_bit: assert property (wb_req_o |-> wb_info_o.status[0])
    else $error("done flag missing");
  chk_req_hold: assert property (wb_req_o && !wb_done_i |=> wb_req_o)
    else $error("write-back dropped");
  chk_head_after: assert property (wb_req_o && wb_done_i |-> ##[0:1] head_adv_o)
    else $error("head not advanced");
  chk_head_step: assert property (head_adv_o |=>
    !head_adv_o && head_o == $past(head_o) + 16'h0001)
    else $error("head step wrong");
endmodule
bind tx_descriptor_command_decode tx_cmd_props u_props (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .desc_ready_o, .data_valid_o,
  .data_ctl_o, .wb_req_o, .wb_info_o, .wb_done_i, .head_adv_o, .head_o);

// [tb/tx_descriptor_command_decode_tb.sv]
`timescale 1ns/100ps
module tx_descriptor_command_decode_tb;
  import tx_cmd_pkg::*;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] checksum_begin_offset;
    logic [7:0] cso;
    logic [3:0] ctl;
  } row_t;
  logic clk_i = 1'b0, rst_i = 1'b1, slow = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, desc_valid_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  desc_t desc_i = '0;
  pkt_ctl_t data_ctl_o;
  wb_t wb_info_o;
  logic wb_ack_o, desc_ready_o, data_valid_o, data_ready_i, wb_req_o;
  logic wb_done_i, head_adv_o, tx_irq_o;
  logic [15:0] head_o, hd;
  logic sent = 1'b0, flush = 1'b0;
  int n_errors = 0, n_checks = 0;
  // length 20; bits five and four kept clear
  row_t rows [9] = '{'{8'h43, 8'h00, 8'h00, 4'hE}, '{8'h41, 8'h00, 8'h00, 4'hE},
    '{8'h46, 8'h00, 8'h00, 4'h0}, '{8'h05, 8'h02, 8'h04, 4'h9},
    '{8'h05, 8'h14, 8'h04, 4'h8}, '{8'h05, 8'h02, 8'h13, 4'h8},
    '{8'h05, 8'h02, 8'h12, 4'h9}, '{8'h0B, 8'h00, 8'h00, 4'hA},
    '{8'h01, 8'h00, 8'h00, 4'h8}};
  always #2 clk_i = ~clk_i;
  tx_descriptor_command_decode u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .desc_valid_i, .desc_i, .desc_ready_o, .data_valid_o, .data_ctl_o,
    .data_ready_i, .sent_i(sent), .wb_req_o, .wb_info_o, .wb_done_i,
    .burst_flush_i(flush), .head_adv_o, .head_o, .tx_irq_o);
  host_mem_model u_host (.clk_i, .rst_i, .slow_i(slow),
    .data_valid_i(data_valid_o), .wb_req_i(wb_req_o),
    .data_ready_o(data_ready_i), .wb_done_o(wb_done_i));
  task automatic print_verdict();
    if (n_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic await(ref logic s);
    for (int i = 0; s !== 1'b1; i++) begin
      if (i > 40) begin
        n_errors++;
        print_verdict();
      end
      @(posedge clk_i);
    end
  endtask
  task automatic bus(logic we, logic [7:0] a, logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    await(wb_ack_o);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // offer is held until the block is seen ready at an edge
  task automatic offer(desc_t d);
    desc_i <= d;
    desc_valid_i <= 1'b1;
    @(posedge clk_i);
    await(desc_ready_o);
    desc_valid_i <= 1'b0;
  endtask
  task automatic send(row_t r);
    offer('{64'h1000, 16'h0014, r.cso, r.cmd, r.checksum_begin_offset, 16'h0000});
    await(data_valid_o);
    check(32'({data_ctl_o.eop, data_ctl_o.vlan, data_ctl_o.fcs,
      data_ctl_o.csum}), 32'(r.ctl));
    if (r.cmd[3]) begin
      await(wb_req_o);
      check(32'(wb_info_o.status), 32'h1);
    end
    await(desc_ready_o);
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(32'({desc_ready_o, tx_irq_o}), 32'h2);
    bus(1'b0, ADDR_VTYPE, 32'h0);
    check(rd, 32'h8100);
    bus(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h3);
    // second pass stalls the host side to catch dropped offers
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      foreach (rows[k]) send(rows[k]);
    end
    repeat (2) @(posedge clk_i);
    check(32'(tx_irq_o), 32'h1);
    bus(1'b1, ADDR_STAT, 32'h0);
    bus(1'b1, ADDR_DELAY, 32'h6);
    send('{8'h8B, 8'h00, 8'h00, 4'hA});
    check(32'(tx_irq_o), 32'h0);
    repeat (10) @(posedge clk_i);
    check(32'(tx_irq_o), 32'h1);
    bus(1'b1, ADDR_CTRL, 32'h2);
    send('{8'h41, 8'h00, 8'h00, 4'h8});
    // report after send: nothing moves until the wire reports
    bus(1'b1, ADDR_CTRL, 32'hA);
    hd = head_o;
    offer('{64'h1000, 16'h0014, 8'h00, 8'h19, 8'h00, 16'h0000});
    await(data_valid_o);
    repeat (5) @(posedge clk_i);
    check(32'({wb_req_o, head_adv_o, desc_ready_o}), 32'h0);
    sent <= 1'b1;
    await(wb_req_o);
    sent <= 1'b0;
    await(desc_ready_o);
    check(32'(head_o), 32'(hd + 16'h0001));
    // null buffer: no data offered, done still written
    offer('{64'h0, 16'h0014, 8'h00, 8'h09, 8'h00, 16'h0000});
    await(wb_req_o);
    check(32'({data_valid_o, wb_info_o.status}), 32'h1);
    await(desc_ready_o);
    // bursting holds the write-back until the flush
    bus(1'b1, ADDR_CTRL, 32'h6);
    offer('{64'h1000, 16'h0014, 8'h00, 8'h09, 8'h00, 16'h0000});
    await(data_valid_o);
    repeat (6) @(posedge clk_i);
    check(32'(wb_req_o), 32'h0);
    flush <= 1'b1;
    await(wb_req_o);
    await(desc_ready_o);
    flush <= 1'b0;
    print_verdict();
  end
endmodule
